// ==== design/config_prom_control.sv ====
`timescale 1ns/1ps
`include "cfg_loader_defs.svh"
module config_prom_control
    import cfg_loader_pkg::*;
#(
    parameter int ADDR_W = `CPC_ADDR_W,
    parameter int DATA_W = `CPC_DATA_W,
    parameter int FIFO_DEPTH = `CPC_FIFO_DEPTH,
    parameter int POR_CYCLES = `CPC_POR_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // configuration pins
    input wire logic config_clock_i,
    input wire logic chip_select_n_i,
    input wire logic busy_i,
    input wire logic oe_reset_n_i,
    output logic oe_reset_n_o,
    output logic oe_reset_oe_n_o,
    input wire logic config_pulse_n_i,
    output logic config_pulse_n_o,
    output logic config_pulse_oe_n_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    output logic forwarded_config_clock_o,
    output logic forwarded_config_clock_oe_n_o,
    output logic cascade_enable_out_n_o,
    output logic standby_o,
    // variant straps
    input wire logic revision_variant_i,
    input wire logic revision_en_i,
    input wire logic parallel_i,
    input wire logic decompress_i,
    input wire logic [ADDR_W-1:0] bank_start_addr_i,
    input wire logic [ADDR_W-1:0] revision_end_address_i,
    // array word stream
    input wire logic mem_valid_i,
    input wire logic [DATA_W-1:0] mem_data_i,
    output logic mem_ready_o,
    output logic mem_restart_o,
    output logic [ADDR_W-1:0] mem_start_addr_o,
    output logic [ADDR_W-1:0] addr_o
);
    // ***********************************************************
    // pin synchronisers
    // ***********************************************************
    localparam int SW = 9 + 2 * ADDR_W;
    localparam int CW = $clog2(POR_CYCLES + 1);
    localparam logic [ADDR_W-1:0] TERMINAL_COUNT = '1;

    logic [SW-1:0] meta_q, sync_q;
    logic clk_prev_q;
    logic cclk_s, ce_n_s, busy_s, oer_n_s, pulse_n_s, rev_var_s, rev_en_s;
    logic par_s, dcmp_s;
    logic [ADDR_W-1:0] start_s, end_s;

    // two flops on every configuration pin and strap level
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
            clk_prev_q <= `CPC_SYNC_RST;
        end else begin
            meta_q <= {config_clock_i, chip_select_n_i, busy_i, oe_reset_n_i,
                       config_pulse_n_i, revision_variant_i, revision_en_i,
                       parallel_i, decompress_i, bank_start_addr_i,
                       revision_end_address_i};
            sync_q <= meta_q;
            clk_prev_q <= sync_q[SW-1];
        end
    end
    assign {cclk_s, ce_n_s, busy_s, oer_n_s, pulse_n_s, rev_var_s, rev_en_s,
            par_s, dcmp_s, start_s, end_s} = sync_q;

    // ***********************************************************
    // address helpers
    // ***********************************************************
    function automatic logic at_limit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lim);
        at_limit = (a == lim);
    endfunction

    function automatic logic [ADDR_W-1:0] reset_addr(input logic rev,
                                                     input logic [ADDR_W-1:0] s);
        reset_addr = rev ? s : ADDR_W'(`CPC_ADDR_ZERO);
    endfunction

    // ***********************************************************
    // fifo in the data path
    // ***********************************************************
    word_fifo_if #(.WIDTH(DATA_W)) fq ();

    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .port(fq.fifo)
    );

    assign fq.push_valid = mem_valid_i && ready_q;
    assign fq.push_data = mem_data_i;

    // ***********************************************************
    // control state
    // ***********************************************************
    cpc_state_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic [CW-1:0] por_q, por_d;
    logic data_oe_n_q, data_oe_n_d, clk_oe_n_q, clk_oe_n_d, ceo_q, ceo_d;
    logic oer_drv_q, oer_drv_d, stby_q, stby_d, fclk_q, fclk_d;
    logic restart_q, restart_d, ready_q, ready_d;
    logic rise, busy_on, rev_lim, flush, pop;

    // next values of the loader
    always_comb begin
        rise = cclk_s && !clk_prev_q;
        busy_on = busy_s && par_s && !dcmp_s;
        rev_lim = rev_var_s && rev_en_s && at_limit(addr_q, end_s);
        state_d = state_q;
        addr_d = addr_q;
        data_d = data_q;
        por_d = por_q;
        data_oe_n_d = 1'b1;
        clk_oe_n_d = 1'b1;
        ceo_d = 1'b1;
        oer_drv_d = 1'b0;
        stby_d = 1'b0;
        fclk_d = cclk_s;
        restart_d = 1'b0;
        flush = 1'b0;
        pop = 1'b0;
        if (state_q == ST_POWERUP) begin
            oer_drv_d = 1'b1;
            if (por_q == CW'(POR_CYCLES - 1)) begin
                state_d = ST_RESET;
                oer_drv_d = 1'b0;
            end else begin
                por_d = por_q + 1'b1;
            end
        end else if (ce_n_s) begin
            // standby overrides the reset input
            state_d = ST_STANDBY;
            addr_d = reset_addr(rev_var_s && rev_en_s, start_s);
            stby_d = 1'b1;
            flush = 1'b1;
            restart_d = 1'b1;
        end else if (!oer_n_s) begin
            state_d = ST_RESET;
            addr_d = reset_addr(rev_var_s && rev_en_s, start_s);
            flush = 1'b1;
            restart_d = 1'b1;
        end else if (rev_var_s && !pulse_n_s) begin
            // pulse low: address reset with outputs still active
            state_d = ST_RUN;
            addr_d = reset_addr(rev_en_s, start_s);
            flush = 1'b1;
            restart_d = 1'b1;
            data_oe_n_d = 1'b0;
            clk_oe_n_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_STANDBY, ST_RESET, ST_RUN: begin
                    state_d = ST_RUN;
                    data_oe_n_d = 1'b0;
                    clk_oe_n_d = !rev_var_s;
                    if (rev_var_s && busy_on) begin
                        // frozen word, clock still forwarded
                    end else if (at_limit(addr_q, TERMINAL_COUNT)) begin
                        state_d = ST_TERM;
                        data_oe_n_d = 1'b1;
                        clk_oe_n_d = 1'b1;
                        ceo_d = 1'b0;
                    end else if (rev_lim) begin
                        state_d = ST_END;
                        data_oe_n_d = 1'b1;
                        clk_oe_n_d = 1'b1;
                    end else if (rise && fq.pop_valid) begin
                        pop = 1'b1;
                        data_d = fq.pop_data;
                        addr_d = addr_q + 1'b1;
                    end
                end
                ST_END: begin
                    state_d = ST_END;
                end
                ST_TERM: begin
                    ceo_d = 1'b0;
                end
                default: begin
                    state_d = ST_RESET;
                end
            endcase
        end
        ready_d = fq.push_ready && !restart_d; // no word taken while the reader restarts
    end

    assign fq.flush = flush;
    assign fq.pop_ready = pop;

    // loader registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_POWERUP;
            addr_q <= '0;
            data_q <= '0;
            por_q <= '0;
            data_oe_n_q <= 1'b1;
            clk_oe_n_q <= 1'b1;
            ceo_q <= 1'b1;
            oer_drv_q <= 1'b1;
            stby_q <= 1'b0;
            fclk_q <= 1'b0;
            restart_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            data_q <= data_d;
            por_q <= por_d;
            data_oe_n_q <= data_oe_n_d;
            clk_oe_n_q <= clk_oe_n_d;
            ceo_q <= ceo_d;
            oer_drv_q <= oer_drv_d;
            stby_q <= stby_d;
            fclk_q <= fclk_d;
            restart_q <= restart_d;
            ready_q <= ready_d;
        end
    end

    // pin outputs
    assign oe_reset_n_o = 1'b0;
    assign oe_reset_oe_n_o = !oer_drv_q;
    assign config_pulse_n_o = 1'b1;
    assign config_pulse_oe_n_o = 1'b1;
    assign data_o = data_q;
    assign data_oe_n_o = data_oe_n_q;
    assign forwarded_config_clock_o = fclk_q;
    assign forwarded_config_clock_oe_n_o = clk_oe_n_q;
    assign cascade_enable_out_n_o = ceo_q;
    assign standby_o = stby_q;
    assign mem_ready_o = ready_q && fq.push_ready;
    assign mem_restart_o = restart_q;
    assign mem_start_addr_o = addr_q;
    assign addr_o = addr_q;

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_STANDBY_ENTRY: assert property ((state_q != ST_POWERUP) && ce_n_s |=> stby_q)
        else $error("chip select high did not give standby");
    AST_STANDBY_OUTS: assert property (stby_q |-> ceo_q && data_oe_n_q && clk_oe_n_q)
        else $error("standby outputs wrong");
    AST_TERM_CEO: assert property ((state_q == ST_TERM) |-> !ceo_q && data_oe_n_q)
        else $error("terminal count outputs wrong");
    AST_TERM_HOLD: assert property ((state_q == ST_TERM) && $stable(state_q) |-> $stable(addr_q))
        else $error("address moved at terminal count");
    AST_STEP_ONE: assert property ($changed(addr_q) && !restart_q |-> addr_q == $past(addr_q) + 1'b1)
        else $error("address stepped by other than one");
    AST_END_HOLD: assert property ((state_q == ST_END) |-> ceo_q && data_oe_n_q && clk_oe_n_q)
        else $error("end address outputs wrong");
    AST_BUSY_FREEZE: assert property (state_q == ST_RUN && rev_var_s && busy_on && oer_n_s && !ce_n_s
            && pulse_n_s |=> $stable(addr_q) && $stable(data_q))
        else $error("flow control did not freeze");
    AST_RESET_ADDR: assert property (!oer_n_s && !ce_n_s && state_q != ST_POWERUP |=>
            addr_q == reset_addr(rev_var_s && rev_en_s, start_s) && data_oe_n_q)
        else $error("reset did not clear address");
    AST_POR_HOLD: assert property ((state_q == ST_POWERUP) |-> !oe_reset_oe_n_o)
        else $error("reset pin released during power-up");
    AST_EDGE_STEP: assert property ($changed(addr_q) && !restart_q |-> $past(rise))
        else $error("address moved without clock edge");

    COV_RUN: cover property (state_q == ST_RUN ##1 $changed(addr_q));
    COV_TERM: cover property (state_q == ST_RUN ##1 state_q == ST_TERM);
    COV_END: cover property (state_q == ST_RUN ##1 state_q == ST_END);
    COV_PULSE: cover property (rev_var_s && !pulse_n_s && oer_n_s && !ce_n_s);
endmodule

// ==== design/cfg_loader_defs.svh ====
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH

// ***********************************************************
// timing
// ***********************************************************
`define CPC_CLK_MHZ 40
`define CPC_TOER_MIN_NS 500000
`define CPC_POR_CYCLES ((`CPC_TOER_MIN_NS * `CPC_CLK_MHZ + 999) / 1000)

// ***********************************************************
// geometry
// ***********************************************************
`define CPC_ADDR_W 20
`define CPC_DATA_W 8
`define CPC_FIFO_DEPTH 32
`define CPC_ADDR_ZERO 0
`define CPC_SYNC_RST 1'b0

`endif

// ==== design/cfg_loader_pkg.sv ====
package cfg_loader_pkg;
    // ***********************************************************
    // control states
    // ***********************************************************
    typedef enum logic [2:0] {
        ST_POWERUP = 3'b000,
        ST_STANDBY = 3'b001,
        ST_RESET   = 3'b010,
        ST_RUN     = 3'b011,
        ST_END     = 3'b100,
        ST_TERM    = 3'b101
    } cpc_state_t;
endpackage

// ==== design/word_fifo_if.sv ====
`timescale 1ns/1ps
// ***********************************************************
// word stream carrier between loader and its fifo
// ***********************************************************
interface word_fifo_if #(parameter int WIDTH = 8);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic flush;
    modport fifo (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready, flush,
                  input push_ready, pop_valid, pop_data);
endinterface

// ==== design/word_fifo.sv ====
`timescale 1ns/1ps
// ***********************************************************
// word fifo with registered read data
// ***********************************************************
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // stream ports
    word_fifo_if.fifo port
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic out_v_q, out_v_d;
    logic do_push, do_pop, load_out;

    // handshake terms
    always_comb begin
        do_push = port.push_valid && port.push_ready && !port.flush;
        load_out = (!out_v_q || port.pop_ready) && (cnt_q != '0);
        do_pop = load_out && !port.flush;
    end
    assign port.push_ready = (cnt_q != DEPTH[PW:0]);
    assign port.pop_valid = out_v_q;
    assign port.pop_data = out_q;

    // pointer and output register next values
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        out_d = out_q;
        out_v_d = out_v_q;
        if (port.flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
            out_v_d = 1'b0;
        end else begin
            if (port.pop_ready && out_v_q) begin
                out_v_d = 1'b0;
            end
            if (do_pop) begin
                out_d = mem[rd_q];
                out_v_d = 1'b1;
                rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (do_push) begin
                wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            cnt_d = cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

    // storage write
    always_ff @(posedge sys_clk_i) begin
        if (do_push) begin
            mem[wr_q] <= port.push_data;
        end
    end

    // state registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            out_v_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            out_v_q <= out_v_d;
        end
    end
endmodule

// ==== testbench/cfg_target_model.sv ====
`timescale 1ns/1ps
// ***********************************************************
// target side: config clock source and reset pin wiring
// ***********************************************************
module cfg_target_model (
    // device pins
    input wire logic oe_reset_n_i,
    input wire logic oe_reset_oe_n_i,
    input wire logic cascade_enable_out_n_i,
    // target controls
    input wire logic hold_reset_i,
    output logic config_clock_o,
    output logic oe_reset_pin_o,
    output logic next_selected_o
);
    // open drain wire with pull-up, target may also hold it low
    assign oe_reset_pin_o = (oe_reset_oe_n_i ? 1'b1 : oe_reset_n_i) & ~hold_reset_i;
    // downstream device takes over on a low cascade output
    assign next_selected_o = ~cascade_enable_out_n_i;
    // clock stands still between bursts
    initial begin
        config_clock_o = 1'b0;
    end
    // burst of n periods of 200 ns
    task automatic clock_burst(input int n);
        for (int i = 0; i < n; i++) begin
            #100 config_clock_o = 1'b1;
            #100 config_clock_o = 1'b0;
        end
    endtask
endmodule

// ==== testbench/config_prom_control_logic_tb.sv ====
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end \
end
module config_prom_control_logic_tb;
    import cfg_loader_pkg::*;
    // ***********************************************************
    // signals
    // ***********************************************************
    logic sys_clk, arst_n, cs_n, busy, pulse_n, hold_rst, mem_valid;
    logic variant, rev_en, par, dec;
    logic [3:0] start_a, end_a, rd_q;
    logic cclk, pin, next_sel, oe_rst_n, oe_rst_oe_n, cfg_p_n, cfg_p_oe_n;
    logic data_oe_n, fclk, fclk_oe_n, casc_n, standby, mem_ready, mem_restart;
    logic [7:0] data;
    logic [3:0] mem_start, addr;
    int n_mismatch = 0;
    int cmp_count = 0;
    // ***********************************************************
    // clock, partner and device
    // ***********************************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    cfg_target_model i_target (
        .oe_reset_n_i(oe_rst_n), .oe_reset_oe_n_i(oe_rst_oe_n),
        .cascade_enable_out_n_i(casc_n), .hold_reset_i(hold_rst),
        .config_clock_o(cclk), .oe_reset_pin_o(pin), .next_selected_o(next_sel)
    );
    config_prom_control #(.ADDR_W(4), .POR_CYCLES(10)) i_dut (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .config_clock_i(cclk),
        .chip_select_n_i(cs_n), .busy_i(busy), .oe_reset_n_i(pin),
        .oe_reset_n_o(oe_rst_n), .oe_reset_oe_n_o(oe_rst_oe_n),
        .config_pulse_n_i(pulse_n), .config_pulse_n_o(cfg_p_n),
        .config_pulse_oe_n_o(cfg_p_oe_n), .data_o(data), .data_oe_n_o(data_oe_n),
        .forwarded_config_clock_o(fclk), .forwarded_config_clock_oe_n_o(fclk_oe_n),
        .cascade_enable_out_n_o(casc_n), .standby_o(standby),
        .revision_variant_i(variant), .revision_en_i(rev_en), .parallel_i(par),
        .decompress_i(dec), .bank_start_addr_i(start_a),
        .revision_end_address_i(end_a), .mem_valid_i(mem_valid),
        .mem_data_i(word_of(rd_q)), .mem_ready_o(mem_ready),
        .mem_restart_o(mem_restart), .mem_start_addr_o(mem_start), .addr_o(addr)
    );
    // array content: each word derived from its address
    function automatic logic [7:0] word_of(input logic [3:0] a);
        return {a, ~a};
    endfunction
    // array reader follows restarts and accepted words
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 4'h0;
        end else if (mem_restart) begin
            rd_q <= mem_start;
        end else if (mem_ready && mem_valid) begin
            rd_q <= rd_q + 4'h1;
        end
    end
    // ***********************************************************
    // helpers
    // ***********************************************************
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // clock burst, then time for sync and update
    task automatic burst(input int n);
        i_target.clock_burst(n);
        wait_cyc(8);
    endtask
    // straps change in standby, then select and let the fifo fill
    task automatic set_mode(input logic v, r, p, d, input logic [3:0] s, e);
        cs_n = 1'b1;
        variant = v;
        rev_en = r;
        par = p;
        dec = d;
        start_a = s;
        end_a = e;
        wait_cyc(6);
        cs_n = 1'b0;
        wait_cyc(45);
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ***********************************************************
    // scenarios
    // ***********************************************************
    task automatic t_power_up;
        wait_cyc(2);
        `CHK("reset pin pulled", 1'b0, oe_rst_oe_n)
        `CHK("reset pin level", 1'b0, pin)
        wait_cyc(20);
        `CHK("reset pin released", 1'b1, oe_rst_oe_n)
    endtask
    // standby ignores the reset pin and the clock
    task automatic t_standby;
        hold_rst = 1'b1;
        burst(2);
        `CHK("standby", 1'b1, standby)
        `CHK("standby addr", 4'h0, addr)
        `CHK("standby cascade", 1'b1, casc_n)
        `CHK("standby data oe", 1'b1, data_oe_n)
        `CHK("standby clk oe", 1'b1, fclk_oe_n)
        hold_rst = 1'b0;
        wait_cyc(4);
        `CHK("standby free pin", 1'b1, standby)
    endtask
    task automatic t_serial;
        set_mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
        `CHK("selected", 1'b0, standby)
        burst(5);
        `CHK("serial addr", 4'h5, addr)
        `CHK("serial data", word_of(4'h4), data)
        `CHK("serial data oe", 1'b0, data_oe_n)
        `CHK("serial cascade", 1'b1, casc_n)
        `CHK("serial clk oe", 1'b1, fclk_oe_n)
        burst(12);
        `CHK("tc addr", 4'hF, addr)
        `CHK("tc cascade", 1'b0, casc_n)
        `CHK("tc data oe", 1'b1, data_oe_n)
        `CHK("tc next device", 1'b1, next_sel)
        burst(2);
        `CHK("tc held", 4'hF, addr)
    endtask
    task automatic t_reset_pin;
        hold_rst = 1'b1;
        burst(3);
        `CHK("pin reset addr", 4'h0, addr)
        `CHK("pin reset cascade", 1'b1, casc_n)
        `CHK("pin reset data oe", 1'b1, data_oe_n)
        `CHK("pin reset standby", 1'b0, standby)
        hold_rst = 1'b0;
        wait_cyc(45);
    endtask
    task automatic t_revision;
        set_mode(1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 4'h7);
        `CHK("bank start", 4'h3, addr)
        burst(2);
        `CHK("rev addr", 4'h5, addr)
        `CHK("rev data", word_of(4'h4), data)
        `CHK("rev clk oe", 1'b0, fclk_oe_n)
        burst(4);
        `CHK("end addr", 4'h7, addr)
        `CHK("end cascade", 1'b1, casc_n)
        `CHK("end data oe", 1'b1, data_oe_n)
        `CHK("end clk oe", 1'b1, fclk_oe_n)
        pulse_n = 1'b0;
        wait_cyc(6);
        `CHK("pulse addr", 4'h3, addr)
        `CHK("pulse data oe", 1'b0, data_oe_n)
        `CHK("pulse pin released", 1'b1, cfg_p_oe_n)
        `CHK("pulse pin level", 1'b1, cfg_p_n)
        pulse_n = 1'b1;
        wait_cyc(45);
        burst(1);
        `CHK("after pulse", 4'h4, addr)
        set_mode(1'b1, 1'b1, 1'b0, 1'b0, 4'hC, 4'hF);
        burst(5);
        `CHK("rev tc addr", 4'hF, addr)
        `CHK("rev tc cascade", 1'b0, casc_n)
        set_mode(1'b1, 1'b0, 1'b0, 1'b0, 4'h9, 4'hF);
        `CHK("no bank start", 4'h0, addr)
    endtask
    task automatic t_busy;
        set_mode(1'b1, 1'b1, 1'b1, 1'b0, 4'h0, 4'hF);
        burst(2);
        busy = 1'b1;
        wait_cyc(4);
        burst(3);
        `CHK("busy addr", 4'h2, addr)
        `CHK("busy data", word_of(4'h1), data)
        `CHK("busy data oe", 1'b0, data_oe_n)
        `CHK("busy clk oe", 1'b0, fclk_oe_n)
        `CHK("busy cascade", 1'b1, casc_n)
        `CHK("fwd clk idle", 1'b0, fclk)
        busy = 1'b0;
        wait_cyc(4);
        burst(1);
        `CHK("busy off", 4'h3, addr)
        set_mode(1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 4'hF);
        busy = 1'b1;
        wait_cyc(4);
        burst(2);
        `CHK("busy ignored", 4'h2, addr)
        busy = 1'b0;
    endtask
    // source stalls: empty fifo holds the address, full fifo refuses
    task automatic t_fifo;
        mem_valid = 1'b0;
        set_mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
        burst(2);
        `CHK("empty fifo addr", 4'h0, addr)
        mem_valid = 1'b1;
        wait_cyc(45);
        `CHK("full fifo ready", 1'b0, mem_ready)
        burst(3);
        `CHK("refill addr", 4'h3, addr)
        `CHK("refill data", word_of(4'h2), data)
    endtask
    // ***********************************************************
    // main sequence and watchdog
    // ***********************************************************
    initial begin
        arst_n = 1'b0;
        cs_n = 1'b1;
        busy = 1'b0;
        pulse_n = 1'b1;
        hold_rst = 1'b0;
        mem_valid = 1'b1;
        {variant, rev_en, par, dec} = 4'h0;
        start_a = 4'h0;
        end_a = 4'h0;
        wait_cyc(5);
        arst_n = 1'b1;
        t_power_up();
        t_standby();
        t_serial();
        t_reset_pin();
        t_revision();
        t_busy();
        t_fifo();
        finish_test();
    end
    initial begin
        #1ms;
        n_mismatch++;
        finish_test();
    end
endmodule
